// >>> hdl/gdp_pkg.sv
// Shared constants and types for the GaN driver protection control block.
package gdp_pkg;

  // Clock.
  localparam int CLK_MHZ       = 100;
  localparam int CLK_PERIOD_NS = 10;

  // Turn-on slew settings in V/ns.
  localparam logic [7:0] SLEW_GND_VNS = 8'h96;  // Pin shorted to ground: 150 V/ns.
  localparam logic [7:0] SLEW_5V_VNS  = 8'h64;  // Pin shorted to the 5 V rail: 100 V/ns.
  localparam logic [7:0] SLEW_MIN_VNS = 8'h14;  // Slowest resistor setting: 20 V/ns.
  localparam int         SLEW_SPAN    = 130;    // 150 V/ns minus 20 V/ns.

  // Resistor measurement code and its noise filter.
  localparam int DRV_CODE_W   = 4;
  localparam int DRV_CODE_MAX = 15;
  localparam int DRV_FILT_US  = 100;
  localparam int DRV_FILT_CYC = DRV_FILT_US * CLK_MHZ;

  // Temperature PWM output.
  localparam int PWM_FREQ_HZ    = 9000;
  localparam int PWM_PERIOD_CYC = (CLK_MHZ * 1000000) / PWM_FREQ_HZ;
  localparam int PWM_CNT_W      = 16;
  localparam int PWM_MIN_HI_NS  = 30;
  localparam int PWM_MIN_HI_CYC = (PWM_MIN_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TEMP_LO_C      = 25;
  localparam int TEMP_HI_C      = 150;
  localparam int DUTY_LO_PCT    = 3;
  localparam int DUTY_HI_PCT    = 82;
  localparam int TEMP_W         = 8;

  // Blanking after a gate command falling edge in diode emulation.
  localparam int BLANK_NS  = 200;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W   = 8;

  // Supply start-up sequence.
  typedef enum logic [1:0] {
    GDP_PWR_RAMP  = 2'b00,
    GDP_PWR_RAILS = 2'b01,
    GDP_PWR_RUN   = 2'b10
  } gdp_pwr_t;

  // Overheat diode emulation states; codes 1..3 match the documented state numbers.
  typedef enum logic [2:0] {
    GDP_DE_NORMAL = 3'b000,
    GDP_DE_BLANK  = 3'b001,
    GDP_DE_WATCH  = 3'b010,
    GDP_DE_CONDUCT = 3'b011,
    GDP_DE_DRVOT  = 3'b100
  } gdp_de_t;

endpackage

// >>> hdl/gdp_sync.sv
// Two-stage synchroniser for the overheat and drain comparator outputs.
`timescale 1ns/10ps
module gdp_sync #(
  parameter int W = 4
) (
  // Clock, reset and enable.
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic         clk_en_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // The first stage is read only by the second stage.
  always_comb begin
    next_meta = async_i;
    next_sync = meta;
  end

  // Both stages hold while the clock enable is low.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else if (clk_en_i) begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end

endmodule

// >>> hdl/gdp_ctrl.sv
// GaN driver control: slew selection, temperature PWM, start-up and overheat diode emulation.
`timescale 1ns/10ps
module gdp_ctrl
  import gdp_pkg::*;
#(
  parameter int PWM_PERIOD = gdp_pkg::PWM_PERIOD_CYC,
  parameter int DRV_FILT   = gdp_pkg::DRV_FILT_CYC
) (
  // Clock, reset and enable.
  input  wire logic                           clock_i,
  input  wire logic                           nrst_i,
  input  wire logic                           clk_en_i,
  // Gate command from the converter controller.
  input  wire logic                           gate_cmd_i,
  // Drive-strength pin measurement.
  input  wire logic                           drv_short_gnd_i,
  input  wire logic                           drv_short_5v_i,
  input  wire logic [gdp_pkg::DRV_CODE_W-1:0] drv_code_i,
  // Supply and rail comparators.
  input  wire logic                           vdd_above_rise_i,
  input  wire logic                           vdd_below_fall_i,
  input  wire logic                           rail5v_ok_i,
  input  wire logic                           negbias_ok_i,
  // Temperature and drain sensing.
  input  wire logic [gdp_pkg::TEMP_W-1:0]     temp_c_i,
  input  wire logic                           fet_ot_i,
  input  wire logic                           drv_ot_i,
  input  wire logic                           drain_neg_i,
  input  wire logic                           drain_q1_i,
  // Outputs.
  output logic                                fet_on_o,
  output logic                                fault_n_o,
  output logic                                temp_pwm_o,
  output logic                                rail_en_o,
  output logic      [7:0]                     slew_vns_o
);
  import gdp_pkg::*;

  // Slew setting from the resistor code; a lower resistance drives faster.
  function automatic logic [7:0] slew_map(input logic [DRV_CODE_W-1:0] code);
    int v;
    v = int'(SLEW_GND_VNS) - (int'(code) * SLEW_SPAN) / DRV_CODE_MAX;
    return v[7:0];
  endfunction

  // High time of the temperature PWM, extended linearly on both sides and clamped.
  function automatic logic [PWM_CNT_W-1:0] pwm_high(input logic [TEMP_W-1:0] t, input int period);
    int lo;
    int span;
    int hi;
    lo   = (period * DUTY_LO_PCT) / 100;
    span = (period * (DUTY_HI_PCT - DUTY_LO_PCT)) / 100;
    hi   = lo + ((int'(t) - TEMP_LO_C) * span) / (TEMP_HI_C - TEMP_LO_C);
    if (hi < PWM_MIN_HI_CYC) begin
      hi = PWM_MIN_HI_CYC;
    end else if (hi > period - 1) begin
      hi = period - 1;
    end
    return hi[PWM_CNT_W-1:0];
  endfunction

  // Synchronised comparator levels.
  logic [3:0] sens_s;
  logic       fet_ot_s;
  logic       drv_ot_s;
  logic       drain_neg_s;
  logic       drain_q1_s;

  // The overheat and drain comparators cross into the clock domain; the supply and rail comparators are used directly.
  gdp_sync #(.W(4)) u_sync (
    .clock_i  (clock_i),
    .nrst_i   (nrst_i),
    .clk_en_i (clk_en_i),
    .async_i  ({fet_ot_i, drv_ot_i, drain_neg_i, drain_q1_i}),
    .sync_o   (sens_s)
  );
  assign {fet_ot_s, drv_ot_s, drain_neg_s, drain_q1_s} = sens_s;

  // Power sequence state.
  gdp_pwr_t pwr;
  gdp_pwr_t next_pwr;
  logic     next_rail_en;

  // Rails build while the supply holds; a dip below the falling threshold drops back to the ramp state.
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      GDP_PWR_RAMP: begin
        if (vdd_above_rise_i) begin
          next_pwr = GDP_PWR_RAILS;
        end
      end
      GDP_PWR_RAILS: begin
        if (vdd_below_fall_i) begin
          next_pwr = GDP_PWR_RAMP;
        end else if (rail5v_ok_i && negbias_ok_i) begin
          next_pwr = GDP_PWR_RUN;
        end
      end
      GDP_PWR_RUN: begin
        if (vdd_below_fall_i) begin
          next_pwr = GDP_PWR_RAMP;
        end
      end
      default: next_pwr = GDP_PWR_RAMP;
    endcase
    // Driver overheat also shuts the regulators, protecting against shorted rail pins.
    next_rail_en = (next_pwr != GDP_PWR_RAMP) && !drv_ot_s;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr       <= GDP_PWR_RAMP;
      rail_en_o <= 1'b0;
    end else if (clk_en_i) begin
      pwr       <= next_pwr;
      rail_en_o <= next_rail_en;
    end
  end

  // Slew selection state.
  logic                  strap_done;
  logic                  strap_5v;
  logic [7:0]            cand;
  logic [7:0]            cand_prev;
  logic [15:0]           filt_cnt;
  logic                  next_strap_done;
  logic                  next_strap_5v;
  logic [7:0]            next_cand_prev;
  logic [15:0]           next_filt_cnt;
  logic [7:0]            next_slew;

  // The rail tie is caught once as the rails come good; a candidate must hold before it is adopted.
  always_comb begin
    next_strap_done = strap_done;
    next_strap_5v   = strap_5v;
    next_cand_prev  = cand_prev;
    next_filt_cnt   = filt_cnt;
    next_slew       = slew_vns_o;
    cand            = drv_short_gnd_i ? SLEW_GND_VNS : slew_map(drv_code_i);
    if (!strap_done && next_pwr == GDP_PWR_RUN) begin
      next_strap_done = 1'b1;
      next_strap_5v   = drv_short_5v_i;
    end
    if (next_strap_5v) begin
      next_slew = SLEW_5V_VNS;
    end else if (cand != cand_prev) begin
      next_cand_prev = cand;
      next_filt_cnt  = 16'h0000;
    end else if (int'(filt_cnt) < DRV_FILT - 1) begin
      next_filt_cnt = filt_cnt + 16'h0001;
    end else begin
      next_slew = cand;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done <= 1'b0;
      strap_5v   <= 1'b0;
      cand_prev  <= SLEW_MIN_VNS;
      filt_cnt   <= 16'h0000;
      slew_vns_o <= SLEW_MIN_VNS;
    end else if (clk_en_i) begin
      strap_done <= next_strap_done;
      strap_5v   <= next_strap_5v;
      cand_prev  <= next_cand_prev;
      filt_cnt   <= next_filt_cnt;
      slew_vns_o <= next_slew;
    end
  end

  // Temperature PWM state.
  logic [PWM_CNT_W-1:0] pwm_cnt;
  logic [PWM_CNT_W-1:0] hi_len;
  logic [PWM_CNT_W-1:0] next_pwm_cnt;
  logic [PWM_CNT_W-1:0] next_hi_len;
  logic                 next_temp_pwm;
  logic                 ot_any;

  // The high time is latched only at period start, so a pulse is never cut short mid-period.
  always_comb begin
    ot_any       = fet_ot_s || drv_ot_s;
    next_pwm_cnt = pwm_cnt + 1'b1;
    next_hi_len  = hi_len;
    if (int'(pwm_cnt) >= PWM_PERIOD - 1) begin
      next_pwm_cnt = '0;
      next_hi_len  = pwm_high(temp_c_i, PWM_PERIOD);
    end
    next_temp_pwm = ot_any || (next_pwm_cnt < next_hi_len);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_cnt    <= '0;
      hi_len     <= PWM_CNT_W'(PWM_MIN_HI_CYC);
      temp_pwm_o <= 1'b0;
    end else if (clk_en_i) begin
      pwm_cnt    <= next_pwm_cnt;
      hi_len     <= next_hi_len;
      temp_pwm_o <= next_temp_pwm;
    end
  end

  // Diode emulation state.
  gdp_de_t             de;
  gdp_de_t             next_de;
  logic [BLANK_W-1:0]  blank_cnt;
  logic [BLANK_W-1:0]  next_blank_cnt;
  logic                gate_prev;
  logic                gate_fall;
  logic                next_fet_on;
  logic                next_fault_n;

  // While only the FET overheats, a falling gate edge overrides every state; without gate activity only states 2 and 3 alternate.
  always_comb begin
    gate_fall      = gate_prev && !gate_cmd_i;
    next_de        = de;
    next_blank_cnt = blank_cnt;
    if (next_pwr != GDP_PWR_RUN) begin
      next_de = GDP_DE_NORMAL;
    end else if (drv_ot_s) begin
      next_de = GDP_DE_DRVOT;
    end else if (!fet_ot_s) begin
      next_de = GDP_DE_NORMAL;
    end else if (gate_fall) begin
      next_de        = GDP_DE_BLANK;
      next_blank_cnt = '0;
    end else begin
      case (de)
        GDP_DE_NORMAL: next_de = GDP_DE_WATCH;
        GDP_DE_DRVOT:  next_de = GDP_DE_WATCH;
        GDP_DE_BLANK: begin
          if (int'(blank_cnt) >= BLANK_CYC - 1) begin
            next_de = GDP_DE_WATCH;
          end else begin
            next_blank_cnt = blank_cnt + 1'b1;
          end
        end
        GDP_DE_WATCH: begin
          if (drain_neg_s) begin
            next_de = GDP_DE_CONDUCT;
          end
        end
        GDP_DE_CONDUCT: begin
          if (drain_q1_s) begin
            next_de = GDP_DE_WATCH;
          end
        end
        default: next_de = GDP_DE_NORMAL;
      endcase
    end
    // Outside overheat the FET follows the gate only once running.
    if (next_de == GDP_DE_NORMAL) begin
      next_fet_on = (next_pwr == GDP_PWR_RUN) && gate_cmd_i;
    end else begin
      next_fet_on = (next_de == GDP_DE_CONDUCT);
    end
    next_fault_n = (next_pwr == GDP_PWR_RUN) && !fet_ot_s && !drv_ot_s;
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      de        <= GDP_DE_NORMAL;
      blank_cnt <= '0;
      gate_prev <= 1'b0;
      fet_on_o  <= 1'b0;
      fault_n_o <= 1'b0;
    end else if (clk_en_i) begin
      de        <= next_de;
      blank_cnt <= next_blank_cnt;
      gate_prev <= gate_cmd_i;
      fet_on_o  <= next_fet_on;
      fault_n_o <= next_fault_n;
    end
  end

  // Checks on the behaviour above.
  chk_rail_slew_fixed: assert property (@(posedge clock_i) disable iff (!nrst_i)
    strap_5v |-> slew_vns_o == 8'h64) else $error("Rail tie did not hold 100 V/ns.");

  chk_strap_frozen: assert property (@(posedge clock_i) disable iff (!nrst_i)
    strap_done |=> strap_done && $stable(strap_5v)) else $error("Rail tie sampled again.");

  chk_gnd_fast_slew: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (clk_en_i && !strap_5v && drv_short_gnd_i && cand_prev == 8'h96 && int'(filt_cnt) >= DRV_FILT - 1)
    |=> slew_vns_o == 8'h96) else $error("Ground short did not select 150 V/ns.");

  chk_slew_range: assert property (@(posedge clock_i) disable iff (!nrst_i)
    slew_vns_o >= 8'h14 && slew_vns_o <= 8'h96) else $error("Slew setting out of range.");

  chk_pwm_min_high: assert property (@(posedge clock_i) disable iff (!nrst_i)
    hi_len >= 16'h0003 && int'(hi_len) < PWM_PERIOD) else $error("PWM high time out of range.");

  chk_ot_temp_high: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (clk_en_i && (fet_ot_s || drv_ot_s)) |=> temp_pwm_o) else $error("Temperature output not high in fault.");

  chk_fall_blanks: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (clk_en_i && pwr == GDP_PWR_RUN && !vdd_below_fall_i && fet_ot_s && !drv_ot_s && gate_fall)
    |=> de == GDP_DE_BLANK && !fet_on_o) else $error("Gate fall did not force blanking.");

  chk_blank_bound: assert property (@(posedge clock_i) disable iff (!nrst_i)
    de == GDP_DE_BLANK |-> !fet_on_o && int'(blank_cnt) < BLANK_CYC) else $error("Blanking overran.");

  chk_conduct_on: assert property (@(posedge clock_i) disable iff (!nrst_i)
    de == GDP_DE_CONDUCT |-> fet_on_o)
    else $error("FET not on while conducting.");

  chk_fault_start: assert property (@(posedge clock_i) disable iff (!nrst_i)
    pwr != GDP_PWR_RUN |-> !fault_n_o && !fet_on_o) else $error("Fault released before run.");

  chk_fault_ot: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (clk_en_i && (fet_ot_s || drv_ot_s)) |=> !fault_n_o) else $error("Fault not low in overtemperature.");

endmodule

// >>> tb/gdp_gate_model.sv
// Converter controller model that drives the gate command of the device.
`timescale 1ns/10ps
module gdp_gate_model (
  // Clock and reset.
  input  wire logic clock_i,
  input  wire logic nrst_i,
  // Toggle every three cycles while run_i is high, else hold level_i.
  input  wire logic run_i,
  input  wire logic level_i,
  // Gate command towards the device.
  output logic      gate_o
);
  int   cnt;
  logic rst_q;
  logic run_q;
  logic level_q;

  // Controls are taken at the edge; the command moves 1 ns later by a non-blocking update,
  // so a bench read in that same step still sees the level the device has just sampled.
  initial begin
    gate_o = 1'b0;
    cnt = 0;
    forever begin
      @(posedge clock_i);
      rst_q   = nrst_i;
      run_q   = run_i;
      level_q = level_i;
      #1;
      if (!rst_q) begin
        gate_o <= 1'b0;
        cnt = 0;
      end else if (run_q) begin
        cnt = cnt + 1;
        if (cnt == 3) begin
          gate_o <= ~gate_o;
          cnt = 0;
        end
      end else begin
        gate_o <= level_q;
      end
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the GaN driver protection control block.
`timescale 1ns/10ps
module tb;
  import gdp_pkg::*;
  localparam int P = 200;
  localparam int F = 8;
  localparam logic [7:0] TEMPS [5] = '{8'h00, 8'h19, 8'h55, 8'h96, 8'hC8};
  typedef struct {int sel; logic [7:0] exp;} gdp_tb_note_t;
  logic       clock_i, nrst_i, run, level, gate, gnd_s, v5_s, rise, fall, r5, nb, fot, dot, dneg, dq1;
  logic [3:0] code;
  logic [7:0] temp, slew, meas_hi, meas_per;
  logic       fet_on, fault_n, pwm, rail_en, blank_ok, en;
  int         error_cnt, checks_done, seed, n, i;
  gdp_tb_note_t q[$];
  event       ev;

  gdp_gate_model i_gdp_gate_model (.clock_i(clock_i), .nrst_i(nrst_i), .run_i(run), .level_i(level), .gate_o(gate));

  gdp_ctrl #(.PWM_PERIOD(P), .DRV_FILT(F)) i_gdp_ctrl (
    .clock_i(clock_i), .nrst_i(nrst_i), .clk_en_i(en), .gate_cmd_i(gate),
    .drv_short_gnd_i(gnd_s), .drv_short_5v_i(v5_s), .drv_code_i(code),
    .vdd_above_rise_i(rise), .vdd_below_fall_i(fall), .rail5v_ok_i(r5), .negbias_ok_i(nb),
    .temp_c_i(temp), .fet_ot_i(fot), .drv_ot_i(dot), .drain_neg_i(dneg), .drain_q1_i(dq1),
    .fet_on_o(fet_on), .fault_n_o(fault_n), .temp_pwm_o(pwm), .rail_en_o(rail_en), .slew_vns_o(slew));

  // Free-running 100 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // Drivers note the expectation; this process compares it with what the outputs show.
  initial begin : monitor
    gdp_tb_note_t nt;
    logic [7:0] got;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        nt = q.pop_front();
        case (nt.sel)
          0: got = {7'h00, fet_on};
          1: got = {7'h00, fault_n};
          2: got = {7'h00, pwm};
          3: got = {7'h00, rail_en};
          4: got = slew;
          5: got = meas_hi;
          6: got = meas_per;
          default: got = {7'h00, blank_ok};
        endcase
        checks_done++;
        if (got !== nt.exp) begin
          error_cnt++;
          $display("MISMATCH t=%0t sel=%0d got=%h exp=%h", $time, nt.sel, got, nt.exp);
        end
      end
    end
  end

  task automatic chk(input int sel, input logic [7:0] exp);
    q.push_back('{sel, exp});
    ->ev;
  endtask

  // Inputs always move 1 ns after the edge.
  task automatic cyc(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask

  task automatic test_done();
    #1;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    nrst_i = 1'b0;
    {rise, fall, r5, nb} = 4'h0;
    repeat (6) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    chk(0, 8'h00);
    chk(2, 8'h00);
    chk(4, 8'h14);
  endtask

  // Supply ramp, optional dip below the falling threshold, then rails good.
  task automatic power_up(input logic glitch);
    cyc(3);
    chk(1, 8'h00);
    chk(3, 8'h00);
    rise = 1'b1;
    cyc(1);
    chk(3, 8'h01);
    chk(1, 8'h00);
    if (glitch) begin
      {rise, fall} = 2'b01;
      cyc(1);
      chk(3, 8'h00);
      {rise, fall} = 2'b10;
      cyc(1);
      chk(3, 8'h01);
    end
    {r5, nb} = 2'b11;
    cyc(1);
    chk(1, 8'h01);
  endtask

  // High time and period of the temperature output, in clock cycles; every wait is bounded.
  task automatic measure();
    int k;
    k = 0;
    meas_hi = 8'h00;
    meas_per = 8'h00;
    while (pwm !== 1'b0 && k < 2 * P) begin cyc(1); k++; end
    while (pwm !== 1'b1 && k < 4 * P) begin cyc(1); k++; end
    while (pwm === 1'b1 && k < 6 * P) begin cyc(1); k++; meas_hi++; end
    while (pwm === 1'b0 && k < 8 * P) begin cyc(1); k++; meas_per++; end
    meas_per = meas_per + meas_hi;
  endtask

  function automatic logic [7:0] exp_hi(input logic [7:0] t);
    int h;
    h = P * 3 / 100 + (int'(t) - 25) * (P * 79 / 100) / 125;
    if (h < 3) h = 3;
    if (h > P - 1) h = P - 1;
    return 8'(h);
  endfunction

  initial begin : main
    seed = 32'h11d9;
    error_cnt = 0;
    checks_done = 0;
    {run, level, gnd_s, v5_s, rise, fall, r5, nb, fot, dot, dneg, dq1, blank_ok} = '0;
    code = 4'h0;
    en = 1'b1;
    temp = 8'h55;
    do_reset();
    power_up(1'b1);
    $display("startup test done");
    run = 1'b1;
    for (i = 0; i < 24; i++) begin cyc(1); chk(0, {7'h00, gate}); end
    {run, level} = 2'b01;
    $display("gate follow test done");
    // Resistor codes first change slowly, well beyond the filter length; then a change shorter than the filter is rejected.
    for (i = 0; i < 6; i++) begin
      code = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
      cyc(2 * F + 4);
      chk(4, 8'(150 - int'(code) * 130 / 15));
    end
    code = code ^ 4'h5;
    cyc(F - 2);
    chk(4, 8'(150 - int'(code ^ 4'h5) * 130 / 15));
    code = code ^ 4'h5;
    cyc(F + 4);
    chk(4, 8'(150 - int'(code) * 130 / 15));
    gnd_s = 1'b1;
    cyc(2 * F + 4);
    chk(4, 8'h96);
    gnd_s = 1'b0;
    $display("slew test done");
    for (i = 0; i < 7; i++) begin
      temp = (i < 5) ? TEMPS[i] : 8'($random(seed));
      cyc(3 * P);
      measure();
      chk(5, exp_hi(temp));
      chk(6, 8'(P));
    end
    $display("temperature test done");
    fot = 1'b1;
    cyc(4);
    chk(0, 8'h00);
    chk(1, 8'h00);
    for (i = 0; i < P + 10; i++) begin cyc(1); chk(2, 8'h01); end
    dneg = 1'b1;
    cyc(4);
    chk(0, 8'h01);
    {dneg, dq1} = 2'b01;
    cyc(4);
    chk(0, 8'h00);
    {dneg, dq1} = 2'b10;
    cyc(4);
    chk(0, 8'h01);
    level = 1'b0;
    n = 0;
    while (fet_on !== 1'b0 && n < 10) begin cyc(1); n++; end
    n = 0;
    while (fet_on !== 1'b1 && n < 40) begin cyc(1); n++; end
    blank_ok = (n >= BLANK_CYC && n <= BLANK_CYC + 4);
    chk(7, 8'h01);
    dot = 1'b1;
    cyc(4);
    chk(0, 8'h00);
    chk(1, 8'h00);
    chk(3, 8'h00);
    dot = 1'b0;
    cyc(5);
    chk(0, 8'h01);
    chk(3, 8'h01);
    {fot, dneg} = 2'b00;
    cyc(4);
    chk(1, 8'h01);
    chk(0, 8'h00);
    measure();
    chk(5, exp_hi(temp));
    $display("overheat test done");
    // A second reset with the pin tied to the 5 V rail freezes the setting.
    v5_s = 1'b1;
    do_reset();
    power_up(1'b0);
    cyc(4);
    chk(4, 8'h64);
    {v5_s, gnd_s} = 2'b01;
    cyc(2 * F + 4);
    chk(4, 8'h64);
    $display("rail tie test done");
    // A low clock enable freezes all state, so a supply dip stays unseen until the enable returns.
    {en, rise, fall} = 3'b001;
    cyc(4);
    chk(1, 8'h01);
    chk(3, 8'h01);
    en = 1'b1;
    cyc(1);
    chk(1, 8'h00);
    chk(3, 8'h00);
    $display("clock enable test done");
    test_done();
  end

  // The whole run takes about 7600 cycles; this limit cuts a hang short.
  initial begin : watchdog
    #300000;
    error_cnt++;
    test_done();
  end
endmodule
